// file: bench/sdcbl_ctrl_model.sv
// Purpose: Controller stand-in driving link clock, commands, write strobes
// Assumes: Bench calls its tasks; pins move on the falling clk edge
// Notes: Link clock stands still between commands
`default_nettype none
module sdcbl_ctrl_model (
   input wire logic clk, // Core clock
   output logic ck, ckN, csN, rasN, casN, weN, // Link clock and command
   output logic [2:0] bankSel, // Bank
   output logic [15:0] dqIn, // Write data
   output logic [1:0] dqsIn, dmIn // Strobes, masks
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ck, ckN, csN, rasN, casN, weN} = 6'h1F;
      bankSel = 3'h0;
      dqIn = 16'h0000;
      {dqsIn, dmIn} = 4'h0;
   end
   // Code held well around the crossing so the synchronisers see one value
   task automatic cmd(input logic [3:0] c, input logic [2:0] b);
      @(negedge clk);
      {csN, rasN, casN, weN} = c;
      bankSel = b;
      repeat (4) @(negedge clk);
      {ck, ckN} = 2'h2;
      repeat (15) @(negedge clk);
      {ck, ckN, csN, rasN, casN, weN} = 6'h1F;
      bankSel = ~b;
      repeat (12) @(negedge clk);
   endtask
   // Strobe edge four clk after data and mask are set; data inverted eight clk after the edge
   task automatic beat(input logic [15:0] d, input logic [1:0] m);
      @(negedge clk);
      dqIn = d;
      dmIn = m;
      repeat (4) @(negedge clk);
      dqsIn = ~dqsIn;
      repeat (8) @(negedge clk);
      dqIn = ~d;
   endtask
endmodule
`default_nettype wire

// file: bench/sdcbl_top_assertions.sv
// Purpose: Port checks on decode, write capture and read strobes
// Assumes: Command pins stay stable for several clk around a crossing
// Notes: Depth 3 spans the two sync flops and the output register
`default_nettype none
`include "sdcbl_defs.vh"
module sdcbl_chk #(
   parameter BANK_W = 3
) (
   input wire logic clk, resetn, csN, rasN, casN, weN, rowOpen, precharge, wrValid,
   input wire logic [BANK_W-1:0] bankSel, cmdBank,
   input wire logic [15:0] dqIn, dqOut, wrData,
   input wire logic [1:0] dmIn, dqOeN, dqsOut, dqsNOut, dqsOeN, wrLaneEn,
   input wire logic [7:0] bankOpen
);
   wire [3:0] code = {csN, rasN, casN, weN};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   property p_row;
      rowOpen |-> $past(code, 3) == `SDCBL_CMD_ROW_OPEN && bankOpen[cmdBank];
   endproperty
   a_row: assert property (p_row) else $error("row open cause");
   property p_pre;
      precharge |-> $past(code, 3) == `SDCBL_CMD_PRECHARGE && !bankOpen[cmdBank];
   endproperty
   a_pre: assert property (p_pre) else $error("precharge cause");
   property p_bank;
      (rowOpen || precharge) |-> cmdBank == $past(bankSel, 3);
   endproperty
   a_bank: assert property (p_bank) else $error("bank");
   property p_wr;
      wrValid |-> wrLaneEn == ~$past(dmIn, 3) && wrData == $past(dqIn, 3);
   endproperty
   a_wr: assert property (p_wr) else $error("write beat");
   property p_wrGap;
      wrValid |=> !wrValid;
   endproperty
   a_wrGap: assert property (p_wrGap) else $error("beat pulse");
   property p_pair;
      dqsOeN == 2'h0 |-> dqsNOut == ~dqsOut;
   endproperty
   a_pair: assert property (p_pair) else $error("strobe pair");
   property p_oe;
      dqOeN == dqsOeN;
   endproperty
   a_oe: assert property (p_oe) else $error("lane enables");
   property p_edge;
      !dqsOeN[0] && $changed(dqOut) |-> $changed(dqsOut[0]);
   endproperty
   a_edge: assert property (p_edge) else $error("read edge");
   c_row: cover property (rowOpen);
   c_wr: cover property (wrValid && wrLaneEn == 2'h1);
   c_rd: cover property (dqsOeN == 2'h0);
endmodule
bind sdcbl_top sdcbl_chk #(.BANK_W(BANK_W)) i_chk (.*);
`default_nettype wire

// file: bench/tb_sdram_cmd_and_byte_lanes.sv
// Purpose: Self-checking bench for command decode and byte lanes
// Assumes: Controller model drives the link side
// Notes: Read words enter through the two-entry buffer
`default_nettype none
`include "sdcbl_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("unexpected %s expected %h seen %h", n, e, a); end end
module tb_sdram_cmd_and_byte_lanes;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, ck, ckN, csN, rasN, casN, weN, rowOpen, precharge;
   logic wrValid, rdValid, rdReady;
   logic [2:0] bankSel, cmdBank;
   logic [15:0] dqIn, dqOut, wrData, rdData, wD;
   logic [1:0] dqOeN, dqsIn, dqsOut, dqsNOut, dqsOeN, dmIn, wrLaneEn, wE;
   logic [7:0] bankOpen;
   int failures = 0;
   int comparisons = 0;
   int wCnt = 0;
   sdcbl_top i_dut (.*);
   sdcbl_ctrl_model i_ctrl (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wrValid) begin
         wCnt <= wCnt + 1;
         wD <= wrData;
         wE <= wrLaneEn;
      end
   end
   task automatic conclude();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic push(input logic [15:0] w);
      @(negedge clk);
      rdValid = 1'b1;
      rdData = w;
      // Ready is a flop, so its level at a falling edge is what the next rising edge takes
      while (!rdReady) @(negedge clk);
      @(negedge clk);
      rdValid = 1'b0;
      rdData = ~w;
   endtask
   task automatic t_row();
      i_ctrl.cmd(`SDCBL_CMD_ROW_OPEN, 3'h3);
      i_ctrl.cmd(`SDCBL_CMD_ROW_OPEN | 4'h8, 3'h5);
      i_ctrl.cmd(4'h1, 3'h6);
      `CHK("banks", 8'h08, bankOpen)
   endtask
   task automatic t_write();
      i_ctrl.cmd(`SDCBL_CMD_WRITE, 3'h3);
      i_ctrl.beat(16'hA55A, 2'h1);
      `CHK("beat0", 16'hA55A, wD)
      `CHK("lanes0", 2'h2, wE)
      i_ctrl.beat(16'h3CC3, 2'h2);
      `CHK("lanes1", 2'h1, wE)
      `CHK("beats", 2, wCnt)
   endtask
   task automatic t_read();
      push(16'h1234);
      push(16'hBEEF);
      repeat (3) @(negedge clk);
      `CHK("full", 1'b0, rdReady)
      i_ctrl.cmd(`SDCBL_CMD_READ, 3'h3);
      // First word leaves on the crossing after the read command
      i_ctrl.cmd(4'h7, 3'h3);
      `CHK("word0", 16'h1234, dqOut)
      `CHK("dqoe", 2'h0, dqOeN)
      `CHK("oe", 2'h0, dqsOeN)
      `CHK("strobe0", 2'h3, dqsOut)
      `CHK("compl0", 2'h0, dqsNOut)
      i_ctrl.cmd(4'h7, 3'h3);
      `CHK("word1", 16'hBEEF, dqOut)
      `CHK("strobe1", 2'h0, dqsOut)
      `CHK("room", 1'b1, rdReady)
   endtask
   task automatic t_pre();
      i_ctrl.cmd(`SDCBL_CMD_PRECHARGE, 3'h3);
      `CHK("bank3", 1'b0, bankOpen[3])
      `CHK("cmdBank", 3'h3, cmdBank)
      i_ctrl.beat(16'h0F0F, 2'h0);
      `CHK("stray", 2, wCnt)
   endtask
   initial begin
      resetn = 1'b0;
      rdValid = 1'b0;
      rdData = 16'h0000;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      t_row();
      t_write();
      t_read();
      t_pre();
      conclude();
   end
   initial begin
      #100000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire

// file: design/sdcbl_buf2.v
// Purpose: Two-entry valid/ready buffer on the read data path
// Assumes: Single clock, source and sink on clk
// Notes: Ready upstream drops only when both entries are full
`default_nettype none

module sdcbl_buf2 #(
   parameter WIDTH = 16
) (
   input wire clk, // Core clock
   input wire resetn, // Async reset, active low
   input wire inValid, // Word offered
   output wire inReady, // Room for a word
   input wire [WIDTH-1:0] inData, // Offered word
   output wire outValid, // Word available
   input wire outReady, // Sink takes word
   output wire [WIDTH-1:0] outData // Head word
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg rdPtr_r;
   reg wrPtr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   assign inReady = (count_r != 2'h2);
   assign outValid = (count_r != 2'h0);
   assign outData = mem_r[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdPtr_r <= 1'b0;
         wrPtr_r <= 1'b0;
         count_r <= 2'h0;
         mem_r[0] <= {WIDTH{1'b0}};
         mem_r[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem_r[wrPtr_r] <= inData;
            wrPtr_r <= ~wrPtr_r;
         end
         if (pop) begin
            rdPtr_r <= ~rdPtr_r;
         end
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end
endmodule

`default_nettype wire

// file: design/sdcbl_defs.vh
// Purpose: Shared constants for the command decoder and byte-lane datapath
// Assumes: Included by bare name from the design files
// Notes: Command codes are {cs_n, ras_n, cas_n, we_n} as sampled
`ifndef SDCBL_DEFS_VH
`define SDCBL_DEFS_VH

`define SDCBL_CMD_ROW_OPEN 4'h3
`define SDCBL_CMD_PRECHARGE 4'h2
`define SDCBL_CMD_READ 4'h5
`define SDCBL_CMD_WRITE 4'h4
`define SDCBL_CMD_CS_BIT 3
`define SDCBL_BYTE_W 8
`define SDCBL_LANE_LO 0
`define SDCBL_LANE_HI 1
`define SDCBL_BURST_LEN 8
`define SDCBL_BANK_W 3

`endif

// file: design/sdcbl_top.v
// Purpose: Device-side command strobe decode and x16 byte-lane strobe/mask logic
// Assumes: Link clock ck and strobes are sampled by clk, several clk per ck cycle
// Notes: No latencies or timing parameters; bursts run until the burst count ends or a decoded command cuts them
`default_nettype none
`include "sdcbl_defs.vh"

module sdcbl_top #(
   parameter BURST_LEN = `SDCBL_BURST_LEN,
   parameter BANK_W = `SDCBL_BANK_W
) (
   input wire clk, // Core clock 250 MHz
   input wire resetn, // Async reset, active low
   input wire ck, // Link clock true
   input wire ckN, // Link clock complement
   input wire csN, // Chip select, active low
   input wire rasN, // Row strobe, active low
   input wire casN, // Column strobe, active low
   input wire weN, // Write enable, active low
   input wire [BANK_W-1:0] bankSel, // Bank address
   input wire [15:0] dqIn, // Data pins, input level
   output reg [15:0] dqOut, // Data pins, driven level
   output reg [1:0] dqOeN, // Per-lane output enable, low drives
   input wire [1:0] dqsIn, // Strobe true pins, input level
   output reg [1:0] dqsOut, // Strobe true, driven level
   output reg [1:0] dqsNOut, // Strobe complement, driven level
   output reg [1:0] dqsOeN, // Strobe pair output enable, low drives
   input wire [1:0] dmIn, // Byte masks, high masks lane
   output reg rowOpen, // Pulse: open row in bank
   output reg precharge, // Pulse: precharge bank
   output reg [BANK_W-1:0] cmdBank, // Bank of last row command
   output reg [7:0] bankOpen, // Open state per bank
   output reg wrValid, // Pulse: write beat captured
   output reg [15:0] wrData, // Captured write beat
   output reg [1:0] wrLaneEn, // Lanes to store for this beat
   input wire rdValid, // Read word offered
   output reg rdReady, // Read path has room
   input wire [15:0] rdData // Read word
);
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WRITE = 2'h2;
   localparam [7:0] LAST_BEAT = BURST_LEN[7:0] - 8'h01;

   // Two-stage synchronisers for every pin
   reg [1:0] ckS1_r, ckS2_r;
   reg [3:0] cmdS1_r, cmdS2_r;
   reg [BANK_W-1:0] baS1_r, baS2_r;
   reg [15:0] dqS1_r, dqS2_r;
   reg [1:0] dqsS1_r, dqsS2_r, dmS1_r, dmS2_r;
   reg ckPrev_r;
   reg [1:0] dqsPrev_r;
   reg [1:0] state_r;
   reg [7:0] beat_r;
   reg half_r;
   wire ckCross;
   wire [1:0] dqsEdge;
   wire [3:0] cmd;
   wire bufValid;
   wire bufInReady;
   wire [15:0] bufData;
   wire bufPop;
   wire lastBeat;
   // Decoded commands, live only on a crossing
   wire cmdLive;
   wire isRowOpen;
   wire isPrecharge;
   wire isRead;
   wire isWrite;
   wire isColumn;
   wire bufPush;
   wire rdFullNxt;
   wire loEdgeWr;
   wire hiEdgeWr;
   wire rdRelease;
   wire [1:0] keepNow;

   function cmdIs;
      input [3:0] code;
      input [3:0] want;
      begin
         cmdIs = (code == want);
      end
   endfunction

   function [1:0] laneKeep;
      input [1:0] mask;
      begin
         laneKeep = ~mask;
      end
   endfunction

   // Crossing: ck rising while its complement is low
   assign ckCross = ckS2_r[0] && !ckS2_r[1] && !ckPrev_r;
   assign dqsEdge = dqsS2_r ^ dqsPrev_r;
   assign cmd = cmdS2_r;
   assign lastBeat = (beat_r == LAST_BEAT);
   // A crossing with chip select high decodes to nothing at all
   assign cmdLive = ckCross && !cmd[`SDCBL_CMD_CS_BIT];
   assign isRowOpen = cmdLive && cmdIs(cmd, `SDCBL_CMD_ROW_OPEN);
   assign isPrecharge = cmdLive && cmdIs(cmd, `SDCBL_CMD_PRECHARGE);
   assign isRead = cmdLive && cmdIs(cmd, `SDCBL_CMD_READ);
   assign isWrite = cmdLive && cmdIs(cmd, `SDCBL_CMD_WRITE);
   assign isColumn = isRead || isWrite;
   // Device launches a beat on each crossing of a read burst while data waits
   assign bufPop = (state_r == ST_READ) && ckCross && bufValid;
   assign bufPush = rdValid && bufInReady;
   // Room is predicted one edge ahead, so a source obeying rdReady never overruns
   assign rdFullNxt = !bufPop && (!bufInReady || (bufValid && bufPush));
   // Each lane follows its own strobe while a write burst runs
   assign loEdgeWr = (state_r == ST_WRITE) && dqsEdge[`SDCBL_LANE_LO];
   assign hiEdgeWr = (state_r == ST_WRITE) && dqsEdge[`SDCBL_LANE_HI];
   // Last read beat stays on the pins until the next crossing; a write frees them at once
   assign rdRelease = (state_r == ST_WRITE) || ((state_r == ST_IDLE) && ckCross);
   assign keepNow = laneKeep(dmS2_r);

   sdcbl_buf2 #(
      .WIDTH(16)
   ) u_rdbuf (
      .clk(clk),
      .resetn(resetn),
      .inValid(rdValid),
      .inReady(bufInReady),
      .inData(rdData),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufData)
   );

   // Link clock and command pins
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ckS1_r <= 2'h0;
         ckS2_r <= 2'h0;
         // Idle code is all ones, so nothing decodes straight out of reset
         cmdS1_r <= 4'hF;
         cmdS2_r <= 4'hF;
         baS1_r <= {BANK_W{1'b0}};
         baS2_r <= {BANK_W{1'b0}};
         ckPrev_r <= 1'b0;
      end else begin
         ckS1_r <= {ckN, ck};
         ckS2_r <= ckS1_r;
         cmdS1_r <= {csN, rasN, casN, weN};
         cmdS2_r <= cmdS1_r;
         baS1_r <= bankSel;
         baS2_r <= baS1_r;
         ckPrev_r <= ckS2_r[0];
      end
   end

   // Data, strobe and mask share one sync depth so a beat stays aligned with its strobe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dqS1_r <= 16'h0000;
         dqS2_r <= 16'h0000;
         dqsS1_r <= 2'h0;
         dqsS2_r <= 2'h0;
         dmS1_r <= 2'h0;
         dmS2_r <= 2'h0;
         dqsPrev_r <= 2'h0;
      end else begin
         dqS1_r <= dqIn;
         dqS2_r <= dqS1_r;
         dqsS1_r <= dqsIn;
         dqsS2_r <= dqsS1_r;
         dmS1_r <= dmIn;
         dmS2_r <= dmS1_r;
         dqsPrev_r <= dqsS2_r;
      end
   end

   // Command decode and row state
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rowOpen <= 1'b0;
         precharge <= 1'b0;
         cmdBank <= {BANK_W{1'b0}};
         bankOpen <= 8'h00;
         state_r <= ST_IDLE;
         beat_r <= 8'h00;
      end else begin
         rowOpen <= 1'b0;
         precharge <= 1'b0;
         // Burst bookkeeping first, so a column command decoded on the same crossing overrides its count and state
         case (state_r)
            ST_IDLE: begin
               beat_r <= 8'h00;
            end
            ST_READ: begin
               if (bufPop) begin
                  beat_r <= beat_r + 8'h01;
                  if (lastBeat) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_WRITE: begin
               if (loEdgeWr) begin
                  beat_r <= beat_r + 8'h01;
                  if (lastBeat) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
         // Any decoded command cuts a running burst; a column command starts a new one
         if (isRowOpen) begin
            rowOpen <= 1'b1;
            cmdBank <= baS2_r;
            bankOpen[baS2_r] <= 1'b1;
            state_r <= ST_IDLE;
         end else if (isPrecharge) begin
            precharge <= 1'b1;
            cmdBank <= baS2_r;
            bankOpen[baS2_r] <= 1'b0;
            state_r <= ST_IDLE;
         end
         if (isColumn) begin
            state_r <= isRead ? ST_READ : ST_WRITE;
            beat_r <= 8'h00;
         end
      end
   end

   // Write capture: lower lane from lower strobe, upper lane from upper strobe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrValid <= 1'b0;
         wrData <= 16'h0000;
         wrLaneEn <= 2'h0;
      end else begin
         wrValid <= 1'b0;
         // Lower strobe marks the beat, so both strobes must be seen on one core clock
         if (loEdgeWr) begin
            wrValid <= 1'b1;
            wrData[`SDCBL_BYTE_W-1:0] <= dqS2_r[`SDCBL_BYTE_W-1:0];
            // Mask taken on the same edge as its beat
            wrLaneEn[`SDCBL_LANE_LO] <= keepNow[`SDCBL_LANE_LO];
         end
         if (hiEdgeWr) begin
            wrData[2*`SDCBL_BYTE_W-1:`SDCBL_BYTE_W] <= dqS2_r[2*`SDCBL_BYTE_W-1:`SDCBL_BYTE_W];
            wrLaneEn[`SDCBL_LANE_HI] <= keepNow[`SDCBL_LANE_HI];
         end
      end
   end

   // Read drive: strobe toggles with each new beat, so edges match data
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dqOut <= 16'h0000;
         dqOeN <= 2'h3;
         dqsOut <= 2'h0;
         dqsNOut <= 2'h3;
         dqsOeN <= 2'h3;
         half_r <= 1'b0;
      end else begin
         if (bufPop) begin
            dqOut <= bufData;
            half_r <= ~half_r;
            dqsOut <= {2{~half_r}};
            // Both halves of the pair leave one edge, so they never skew
            dqsNOut <= {2{half_r}};
            dqOeN <= 2'h0;
            dqsOeN <= 2'h0;
         end else if (rdRelease) begin
            dqOeN <= 2'h3;
            dqsOeN <= 2'h3;
            half_r <= 1'b0;
            dqsOut <= 2'h0;
            dqsNOut <= 2'h3;
         end
      end
   end

   // Room flag is a flop like every other output
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdReady <= 1'b0;
      end else begin
         rdReady <= !rdFullNxt;
      end
   end
endmodule

`default_nettype wire
